/* core/segment_lcd_frame_control.sv */
// Frame control of a passive segment LCD: registers, scan, capture, pin drive.
// Assumes a single AHB-Lite master on hclk; analog levels are handled outside.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_regs_regs.svh"
module segment_lcd_frame_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic async_oscillator_pin,
  input wire logic frame_irq_ack,
  output logic frame_irq,
  output logic external_clock_input_enable,
  output logic clock_from_async,
  output logic half_bias_select,
  output logic [3:0] contrast_working,
  output logic blank_active,
  output logic [24:0] frontplane_drive_pin,
  output logic [24:0] segment_pin_active,
  output logic [3:0] backplane_drive_pin,
  output logic [3:0] backplane_pin_active
);
  localparam logic [39:0] SEG_COUNTS = `LCD_SEG_COUNTS;

  // Register file
  logic enable_reg, enable_next;
  logic lpw_reg, lpw_next;
  logic ie_reg, ie_next;
  logic blank_reg, blank_next;
  logic flag_reg, flag_next;
  logic clksel_reg, clksel_next;
  logic halfbias_reg, halfbias_next;
  logic extclk_reg, extclk_next;
  logic [1:0] duty_reg, duty_next;
  logic [2:0] mask_reg, mask_next;
  logic [6:0] frr_reg, frr_next;
  logic [3:0] contrast_reg, contrast_next;
  // Bus pipeline
  logic wr_q_reg, wr_q_next;
  logic mem_sel_reg, mem_sel_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic addr_phase;
  logic mem_wr;
  logic flag_clear;
  logic [24:0] mem_rdata;
  // Frame engine
  lcd_pkg::scan_state_type state_reg, state_next;
  logic [10:0] presc_reg, presc_next;
  logic [1:0] com_reg, com_next;
  logic phase_reg, phase_next;
  logic hold_reg, hold_next;
  logic lpw_cur_reg, lpw_cur_next;
  logic blank_cur_reg, blank_cur_next;
  logic [3:0] contrast_cur_reg, contrast_cur_next;
  logic osc_rise;
  logic src_tick;
  logic slot_tick;
  logic frame_start;
  logic capture;
  logic [99:0] snap_data;
  // Pin drive
  logic [24:0] seg_out_next, seg_act_next;
  logic [3:0] com_out_next, com_act_next;
  lcd_pkg::seg_word_type seg_word;
  logic [4:0] seg_count;

  pin_sync u_osc_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(async_oscillator_pin),
    .rise(osc_rise)
  );

  display_memory u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(mem_wr),
    .wr_addr(addr_reg[3:2]),
    .wr_data(hwdata[24:0]),
    .rd_addr(haddr[3:2]),
    .rd_data(mem_rdata),
    .snap(capture),
    .snap_data(snap_data)
  );

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel && hready && htrans[1];
  assign mem_wr = wr_q_reg && addr_reg[7:4] == `LCD_MEM_PAGE;
  assign flag_clear = wr_q_reg && addr_reg == `LCD_CTRL_A_OFS && hwdata[`LCD_CA_FLAG];
  assign hrdata = mem_sel_reg ? {7'h0, mem_rdata} : rdata_reg;

  always_comb begin
    wr_q_next = addr_phase && hwrite;
    mem_sel_next = addr_phase && !hwrite && haddr[7:4] == `LCD_MEM_PAGE;
    addr_next = addr_phase ? haddr[7:0] : addr_reg;
    rdata_next = 32'h0;
    if (!addr_phase || hwrite) begin
      rdata_next = 32'h0;
    end else if (haddr[7:0] == `LCD_CTRL_A_OFS) begin
      rdata_next[`LCD_CA_ENABLE] = enable_reg;
      rdata_next[`LCD_CA_LPW] = lpw_reg;
      rdata_next[`LCD_CA_FLAG] = flag_reg;
      rdata_next[`LCD_CA_IE] = ie_reg;
      rdata_next[`LCD_CA_BLANK] = blank_reg;
    end else if (haddr[7:0] == `LCD_CTRL_B_OFS) begin
      rdata_next[7:0] = {clksel_reg, halfbias_reg, duty_reg, 1'b0, mask_reg};
    end else if (haddr[7:0] == `LCD_FRAME_RATE_OFS) begin
      rdata_next[6:0] = frr_reg;
    end else if (haddr[7:0] == `LCD_CONTRAST_OFS) begin
      rdata_next[3:0] = contrast_reg;
    end else if (haddr[7:0] == `LCD_ASYNC_OFS) begin
      rdata_next[`LCD_ASYNC_EXTCLK] = extclk_reg;
    end else if (haddr[7:0] == `LCD_STATUS_OFS) begin
      rdata_next[10:0] = {contrast_cur_reg, state_reg == lcd_pkg::SCAN_RUN,
                          hold_reg, com_reg, phase_reg, lpw_cur_reg, blank_cur_reg};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q_reg <= 1'b0;
      mem_sel_reg <= 1'b0;
      addr_reg <= 8'h0;
      rdata_reg <= 32'h0;
    end else begin
      wr_q_reg <= wr_q_next;
      mem_sel_reg <= mem_sel_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // Control registers; writes land in the data phase
  always_comb begin
    enable_next = enable_reg;
    lpw_next = lpw_reg;
    ie_next = ie_reg;
    blank_next = blank_reg;
    clksel_next = clksel_reg;
    halfbias_next = halfbias_reg;
    duty_next = duty_reg;
    mask_next = mask_reg;
    frr_next = frr_reg;
    contrast_next = contrast_reg;
    extclk_next = extclk_reg;
    if (!wr_q_reg) begin
      enable_next = enable_reg;
    end else if (addr_reg == `LCD_CTRL_A_OFS) begin
      enable_next = hwdata[`LCD_CA_ENABLE];
      lpw_next = hwdata[`LCD_CA_LPW];
      ie_next = hwdata[`LCD_CA_IE];
      blank_next = hwdata[`LCD_CA_BLANK];
    end else if (addr_reg == `LCD_CTRL_B_OFS) begin
      clksel_next = hwdata[`LCD_CB_CLKSEL];
      halfbias_next = hwdata[`LCD_CB_HALFBIAS];
      duty_next = hwdata[`LCD_CB_DUTY +: 2];
      mask_next = hwdata[`LCD_CB_MASK +: 3];
    end else if (addr_reg == `LCD_FRAME_RATE_OFS) begin
      frr_next = hwdata[6:0];
    end else if (addr_reg == `LCD_CONTRAST_OFS) begin
      contrast_next = hwdata[3:0];
    end else if (addr_reg == `LCD_ASYNC_OFS) begin
      extclk_next = hwdata[`LCD_ASYNC_EXTCLK];
    end
    // Hardware set wins over ack or write-one clear
    flag_next = capture || (flag_reg && !flag_clear && !frame_irq_ack);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= 1'b0;
      lpw_reg <= 1'b0;
      ie_reg <= 1'b0;
      blank_reg <= 1'b0;
      flag_reg <= 1'b0;
      clksel_reg <= 1'b0;
      halfbias_reg <= 1'b0;
      extclk_reg <= 1'b0;
      duty_reg <= `LCD_DUTY_RST;
      mask_reg <= `LCD_MASK_RST;
      frr_reg <= `LCD_FRR_RST;
      contrast_reg <= `LCD_CONTRAST_RST;
    end else begin
      enable_reg <= enable_next;
      lpw_reg <= lpw_next;
      ie_reg <= ie_next;
      blank_reg <= blank_next;
      flag_reg <= flag_next;
      clksel_reg <= clksel_next;
      halfbias_reg <= halfbias_next;
      extclk_reg <= extclk_next;
      duty_reg <= duty_next;
      mask_reg <= mask_next;
      frr_reg <= frr_next;
      contrast_reg <= contrast_next;
    end
  end

  assign frame_irq = flag_reg && ie_reg;
  assign clock_from_async = clksel_reg;
  assign external_clock_input_enable = extclk_reg && clksel_reg;

  // No sleep gating here: hclk or the pin tick keeps the scan alive
  assign src_tick = clksel_reg ? osc_rise : 1'b1;
  assign slot_tick = src_tick && presc_reg == {frr_reg, `LCD_PRESC_FILL};
  assign frame_start = state_reg == lcd_pkg::SCAN_RUN && slot_tick && com_reg >= duty_reg;
  // Low-power mode skips the capture of every second frame
  assign capture = frame_start && !hold_reg;

  always_comb begin
    state_next = state_reg;
    presc_next = presc_reg;
    com_next = com_reg;
    phase_next = phase_reg;
    hold_next = hold_reg;
    lpw_cur_next = lpw_cur_reg;
    blank_cur_next = blank_cur_reg;
    contrast_cur_next = contrast_cur_reg;
    case (state_reg)
      lcd_pkg::SCAN_OFF: begin
        presc_next = 11'h0;
        com_next = 2'h3;
        hold_next = 1'b0;
        if (enable_reg) begin
          state_next = lcd_pkg::SCAN_RUN;
        end
      end
      lcd_pkg::SCAN_RUN: begin
        if (!enable_reg) begin
          state_next = lcd_pkg::SCAN_OFF;
        end
        if (src_tick) begin
          presc_next = slot_tick ? 11'h0 : presc_reg + 11'h1;
        end
        if (slot_tick) begin
          // Reduced toggling: phase flips per frame, not per slot
          phase_next = lpw_cur_reg ? phase_reg : ~phase_reg;
          if (com_reg >= duty_reg) begin
            com_next = 2'h0;
            hold_next = capture && lpw_reg;
            if (lpw_cur_reg) begin
              phase_next = ~phase_reg;
            end
          end else begin
            com_next = com_reg + 2'h1;
          end
        end
        if (capture) begin
          lpw_cur_next = lpw_reg;
          blank_cur_next = blank_reg;
          contrast_cur_next = contrast_reg;
        end
      end
      default: begin
        state_next = lcd_pkg::SCAN_OFF;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= lcd_pkg::SCAN_OFF;
      presc_reg <= 11'h0;
      com_reg <= 2'h3;
      phase_reg <= 1'b0;
      hold_reg <= 1'b0;
      lpw_cur_reg <= 1'b0;
      blank_cur_reg <= 1'b0;
      contrast_cur_reg <= `LCD_CONTRAST_RST;
    end else begin
      state_reg <= state_next;
      presc_reg <= presc_next;
      com_reg <= com_next;
      phase_reg <= phase_next;
      hold_reg <= hold_next;
      lpw_cur_reg <= lpw_cur_next;
      blank_cur_reg <= blank_cur_next;
      contrast_cur_reg <= contrast_cur_next;
    end
  end

  // Pin drive; blanking only forces levels, memory stays intact
  assign seg_word = snap_data[25 * com_reg +: 25];
  assign seg_count = SEG_COUNTS[5 * mask_reg +: 5];

  genvar i;
  generate
    for (i = 0; i < 25; i++) begin : g_seg
      always_comb begin
        seg_act_next[i] = enable_reg && 5'(i) < seg_count;
        seg_out_next[i] = !blank_cur_reg && (seg_word[i] ^ phase_reg);
      end
    end
    for (i = 0; i < 4; i++) begin : g_com
      always_comb begin
        com_act_next[i] = enable_reg && 2'(i) <= duty_reg;
        com_out_next[i] = !blank_cur_reg && ((com_reg == 2'(i)) ^ phase_reg);
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frontplane_drive_pin <= 25'h0;
      segment_pin_active <= 25'h0;
      backplane_drive_pin <= 4'h0;
      backplane_pin_active <= 4'h0;
      blank_active <= 1'b0;
      contrast_working <= 4'h0;
      half_bias_select <= 1'b0;
    end else begin
      frontplane_drive_pin <= seg_out_next;
      segment_pin_active <= seg_act_next;
      backplane_drive_pin <= com_out_next;
      backplane_pin_active <= com_act_next;
      blank_active <= blank_cur_reg;
      contrast_working <= contrast_cur_reg;
      half_bias_select <= halfbias_reg && duty_reg != 2'h0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence frame_edge_s;
    frame_start && !hold_reg;
  endsequence
  sequence flag_up_s;
    ##1 flag_reg;
  endsequence

  chk_flag_set_capture: assert property (frame_edge_s |-> flag_up_s)
    else $error("frame flag not set at capture");
  chk_lp_skip_frame: assert property (capture && lpw_reg |=> hold_reg)
    else $error("low-power frame did not hold");
  chk_held_no_flag: assert property (frame_start && hold_reg && !flag_reg |=> !flag_reg)
    else $error("flag set in held low-power frame");
  chk_lp_phase_hold: assert property (
    lpw_cur_reg && slot_tick && !frame_start |=> $stable(phase_reg))
    else $error("low-power phase toggled mid frame");
  chk_blank_ground: assert property (blank_cur_reg |=>
    (frontplane_drive_pin == 25'h0 && backplane_drive_pin == 4'h0))
    else $error("blanked pins not at ground");
  chk_capture_copy: assert property (capture |=>
    contrast_cur_reg == $past(contrast_reg) && blank_cur_reg == $past(blank_reg))
    else $error("frame copies not captured");
  chk_disable_release: assert property (!enable_reg |=>
    segment_pin_active == 25'h0 && backplane_pin_active == 4'h0)
    else $error("pins not released on disable");
  chk_duty_commons: assert property (enable_reg && duty_reg == 2'h1 |=>
    backplane_pin_active == 4'h3)
    else $error("wrong commons for half duty");
  chk_mask_minimum: assert property (enable_reg && mask_reg == 3'h0 |=>
    segment_pin_active == 25'h1fff)
    else $error("mask zero not 13 segments");
  chk_com_ascend: assert property (slot_tick && state_reg == lcd_pkg::SCAN_RUN &&
    com_reg < duty_reg |=> com_reg == $past(com_reg) + 2'h1)
    else $error("common did not step up");
  chk_contrast_live: assert property (wr_q_reg && addr_reg == `LCD_CONTRAST_OFS |=>
    contrast_reg == $past(hwdata[3:0]))
    else $error("contrast write lost");
endmodule // segment_lcd_frame_control
`default_nettype wire

/* core/lcd_regs_regs.svh */
// Register map, field positions, reset values and timing figures of the LCD frame controller.
// Assumes one AHB-Lite slave window decoded on haddr[7:0].
`ifndef LCD_REGS_REGS_SVH
`define LCD_REGS_REGS_SVH
`define LCD_CTRL_A_OFS 8'h00
`define LCD_CTRL_B_OFS 8'h04
`define LCD_FRAME_RATE_OFS 8'h08
`define LCD_CONTRAST_OFS 8'h0c
`define LCD_ASYNC_OFS 8'h10
`define LCD_STATUS_OFS 8'h14
`define LCD_MEM_PAGE 4'h4
`define LCD_CA_ENABLE 7
`define LCD_CA_LPW 6
`define LCD_CA_FLAG 4
`define LCD_CA_IE 3
`define LCD_CA_BLANK 0
`define LCD_CB_CLKSEL 7
`define LCD_CB_HALFBIAS 6
`define LCD_CB_DUTY 4
`define LCD_CB_MASK 0
`define LCD_ASYNC_EXTCLK 0
`define LCD_DUTY_RST 2'h0
`define LCD_MASK_RST 3'h0
`define LCD_FRR_RST 7'h00
`define LCD_CONTRAST_RST 4'h0
`define LCD_PRESC_FILL 4'hf
`define LCD_SEG_COUNTS {5'd25, 5'd24, 5'd23, 5'd21, 5'd19, 5'd17, 5'd15, 5'd13}
`endif

/* core/lcd_pkg.sv */
// Types shared by the LCD frame controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package lcd_pkg;
  typedef enum logic [1:0] {
    SCAN_OFF = 2'b01,
    SCAN_RUN = 2'b10
  } scan_state_type;
  typedef logic [24:0] seg_word_type;
endpackage

/* core/pin_sync.sv */
// Three-flop synchroniser for the asynchronous oscillator pin.
// Assumes the pin toggles much slower than hclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic rise
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic stable_reg;
  logic stable_next;
  logic rise_next;

  always_comb begin
    sync_next = {sync_reg[1:0], pin_in};
    stable_next = stable_reg;
    rise_next = 1'b0;
    // Change counts only when the second and third stages agree
    if (sync_reg[1] == sync_reg[2]) begin
      stable_next = sync_reg[2];
      rise_next = sync_reg[2] & ~stable_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_reg <= 3'h0;
      stable_reg <= 1'b0;
      rise <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      stable_reg <= stable_next;
      rise <= rise_next;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* core/display_memory.sv */
// Display memory, one 25-bit word per common, with a frame snapshot.
// Assumes the bus and the frame engine share hclk.
`timescale 1ns/1ps
`default_nettype none
module display_memory (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [24:0] wr_data,
  input wire logic [1:0] rd_addr,
  output logic [24:0] rd_data,
  input wire logic snap,
  output logic [99:0] snap_data
);
  logic [24:0] mem_reg [4];
  logic [24:0] mem_next [4];
  logic [99:0] snap_next;
  logic [24:0] rd_next;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_word
      always_comb begin
        mem_next[i] = (wr_en && wr_addr == 2'(i)) ? wr_data : mem_reg[i];
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mem_reg[i] <= 25'h0;
        end else begin
          mem_reg[i] <= mem_next[i];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_next = mem_reg[rd_addr];
    snap_next = snap ? {mem_reg[3], mem_reg[2], mem_reg[1], mem_reg[0]} : snap_data;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= 25'h0;
      snap_data <= 100'h0;
    end else begin
      rd_data <= rd_next;
      snap_data <= snap_next;
    end
  end
endmodule // display_memory
`default_nettype wire

/* dv/lcd_panel_model.sv */
// Passive four-common panel model watching the common terminals.
// Assumes the scan is judged only while all four commons are owned and unblanked.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  input wire logic hclk,
  input wire logic [3:0] backplane_drive_pin,
  input wire logic [3:0] backplane_pin_active,
  input wire logic blank_active,
  output int frames,
  output int order_errs
);
  logic [3:0] prev;
  int last;
  int idx;

  // Addressed common is the one whose level differs from all others
  function automatic int odd_one(input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      if (b[i] !== b[(i + 1) % 4] && b[i] !== b[(i + 2) % 4]) begin
        return i;
      end
    end
    return -1;
  endfunction

  initial begin
    frames = 0;
    order_errs = 0;
    last = -1;
    prev = 4'h0;
  end

  always @(posedge hclk) begin
    if (backplane_pin_active !== 4'hf || blank_active !== 1'b0) begin
      last = -1;
    end else if (backplane_drive_pin !== prev) begin
      idx = odd_one(backplane_drive_pin);
      if (last >= 0 && idx != (last + 1) % 4) begin
        order_errs++;
      end
      if (idx == 0) begin
        frames++;
      end
      last = idx;
    end
    prev = backplane_drive_pin;
  end
endmodule // lcd_panel_model
`default_nettype wire

/* dv/segment_lcd_frame_control_tb_top.sv */
// Self-checking bench of the LCD frame controller over AHB-Lite.
// Assumes zero-wait slave, frame rate 0 (16 hclk per slot) for short frames.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_regs_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module segment_lcd_frame_control_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, osc = 1'b0, ack = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic hreadyout, hresp, irq, extclk, async_sel, half, blank;
  logic [3:0] contrast, bp, bp_act;
  logic [24:0] fp, fp_act;
  logic [24:0] mem [4];
  logic [3:0] c1;
  int num_errors = 0, n_checks = 0, cycles = 0, f0, i;
  logic [31:0] seed = 32'hefa6;

  segment_lcd_frame_control segment_lcd_frame_control_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .async_oscillator_pin(osc), .frame_irq_ack(ack), .frame_irq(irq),
    .external_clock_input_enable(extclk), .clock_from_async(async_sel),
    .half_bias_select(half), .contrast_working(contrast), .blank_active(blank),
    .frontplane_drive_pin(fp), .segment_pin_active(fp_act), .backplane_drive_pin(bp),
    .backplane_pin_active(bp_act));
  lcd_panel_model lcd_panel_model_inst (.hclk(hclk), .backplane_drive_pin(bp),
    .backplane_pin_active(bp_act), .blank_active(blank), .frames(), .order_errs());

  initial forever #20 hclk = ~hclk;
  // Oscillator pin at a rate unrelated to hclk
  initial forever #170 osc = ~osc;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [24:0] seg_mask(input logic [2:0] m);
    logic [4:0] n;
    n = (m < 3'd6) ? 5'd13 + 5'd2 * m : 5'd18 + m;
    return (25'h1 << n) - 25'h1;
  endfunction

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= wr; htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wait_frame();
    int k;
    k = 0;
    // Drop a flag left from an earlier frame so only a fresh start counts
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    @(posedge hclk);
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    `CHK(irq, 1'b1)
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic chk_slots();
    int idx;
    repeat (4) begin
      idx = lcd_panel_model_inst.odd_one(bp);
      `CHK(fp ^ {25{bp[idx]}}, ~mem[idx])
      repeat (16) @(posedge hclk);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (mem[k]) mem[k] = 25'h0;
    for (i = 0; i < 6; i++) begin
      ahb(1'b0, (i == 5) ? 8'h80 : 8'(4 * i), 32'h0);
      `CHK({hresp, rdv}, 33'h0)
    end
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      ahb(1'b1, `LCD_CTRL_B_OFS, {24'h0, 1'b0, 1'(i < 2), 2'(i), 1'b0, seed[2:0]});
      ahb(1'b1, `LCD_CTRL_A_OFS, 32'h88);
      repeat (3) @(posedge hclk);
      `CHK(bp_act, 4'((5'h1 << (i + 1)) - 5'h1))
      `CHK(fp_act, seg_mask(seed[2:0]))
      `CHK(half, 1'(i == 1))
      ahb(1'b1, `LCD_CTRL_A_OFS, 32'h0);
      repeat (2) @(posedge hclk);
      `CHK({fp_act, bp_act}, 29'h0)
    end
    $display("test duty and mask done");
    seed = xs(seed);
    c1 = seed[3:0];
    ahb(1'b1, `LCD_CTRL_B_OFS, 32'h37);
    ahb(1'b1, `LCD_CONTRAST_OFS, {28'h0, c1});
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      mem[i] = seed[24:0];
      ahb(1'b1, 8'h40 + 8'(4 * i), {7'h0, mem[i]});
    end
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'h88);
    wait_frame();
    f0 = lcd_panel_model_inst.frames;
    wait_frame();
    `CHK(lcd_panel_model_inst.frames - f0, 1)
    `CHK(contrast, c1)
    chk_slots();
    `CHK(lcd_panel_model_inst.order_errs, 0)
    ahb(1'b1, `LCD_CONTRAST_OFS, {28'h0, ~c1});
    seed = xs(seed);
    mem[0] = seed[24:0];
    ahb(1'b1, 8'h40, {7'h0, mem[0]});
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(rdv, {7'h0, mem[0]})
    `CHK(contrast, c1)
    wait_frame();
    `CHK(contrast, ~c1)
    chk_slots();
    $display("test capture done");
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'h89);
    `CHK(blank, 1'b0)
    wait_frame();
    `CHK({blank, fp, bp}, {1'b1, 29'h0})
    for (i = 0; i < 4; i++) begin
      ahb(1'b0, 8'h40 + 8'(4 * i), 32'h0);
      `CHK(rdv, {7'h0, mem[i]})
    end
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'h88);
    wait_frame();
    chk_slots();
    $display("test blanking done");
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'hc8);
    wait_frame();
    ahb(1'b0, `LCD_STATUS_OFS, 32'h0);
    `CHK(rdv[1], 1'b1)
    wait_frame();
    f0 = lcd_panel_model_inst.frames;
    wait_frame();
    `CHK(lcd_panel_model_inst.frames - f0, 2)
    // Let the next captured frame raise the flag, then clear it by writing one
    repeat (130) @(posedge hclk);
    ahb(1'b0, `LCD_CTRL_A_OFS, 32'h0);
    `CHK(rdv[4], 1'b1)
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'h98);
    ahb(1'b0, `LCD_CTRL_A_OFS, 32'h0);
    `CHK(rdv[4], 1'b0)
    $display("test low power done");
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'h89);
    wait_frame();
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'h0);
    ahb(1'b1, `LCD_ASYNC_OFS, 32'h1);
    ahb(1'b1, `LCD_CTRL_B_OFS, 32'h87);
    repeat (2) @(posedge hclk);
    `CHK({extclk, async_sel}, 2'b11)
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'h88);
    wait_frame();
    ahb(1'b1, `LCD_CTRL_A_OFS, 32'h0);
    ahb(1'b1, `LCD_CTRL_B_OFS, 32'h07);
    repeat (2) @(posedge hclk);
    `CHK({extclk, async_sel}, 2'b00)
    $display("test async clock done");
    conclude();
  end
endmodule // segment_lcd_frame_control_tb_top
`default_nettype wire
